/* design/scs_consts.svh */
/*
  timing and reset constants for the sampled comparator sequencer.
  assumes a 25 mhz system clock; every count is derived from a time.
*/
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define SCS_CLK_PERIOD_NS 40

// ----------------------------------------------------------------
// active window and input settling
// ----------------------------------------------------------------
`define SCS_WIN_NS 80000
`define SCS_WIN_CYC (`SCS_WIN_NS / `SCS_CLK_PERIOD_NS)
`define SCS_SETTLE_NS 4000
`define SCS_SETTLE_CYC ((`SCS_SETTLE_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// self-timed sample period (default timing_resistor / timing_capacitor pair, 5 hz)
// ----------------------------------------------------------------
`define SCS_OSC_PERIOD_NS 200000000
`define SCS_OSC_PERIOD_CYC (`SCS_OSC_PERIOD_NS / `SCS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
// both results low after reset, so both_low starts high and on_off starts low
`define SCS_RST_RESULT 4'h2
`define SCS_RST_SYNC 4'h0

`endif

/* design/scs_pkg.sv */
/*
  types shared by the sampled comparator sequencer files.
  assumes nothing of its surroundings.
*/
`default_nettype none

package scs_pkg;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    SCS_IDLE = 2'b01,
    SCS_ACTIVE = 2'b10
  } scs_state_e;

  // the four logic outputs, travelling together
  typedef struct packed {
    logic a;
    logic b;
    logic both_low;
    logic on_off;
  } scs_result_s;

endpackage

`default_nettype wire

/* design/scs_osc.sv */
/*
  self-timed sample oscillator: a one-cycle tick every PERIOD cycles.
  assumes run is a clean level on clk; the count restarts while run is low.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_osc #(
  parameter int PERIOD = 5000000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(PERIOD + 1);

  logic [CW-1:0] cnt_ff;
  logic tick_ff;

  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  // restarting on stop keeps the first self-timed sample a full period away
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == CW'(PERIOD - 1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule

`default_nettype wire

/* design/scs_top.sv */
/*
  sequencer and output logic of a dual sampled comparator.
  assumes the analog front end presents each channel's sum sign as a pin level,
  and that strobe and the rc_timing_pin grounded sense are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.svh"

module scs_top #(
  parameter int OSC_PERIOD = `SCS_OSC_PERIOD_CYC,
  parameter int WIN_CYC = `SCS_WIN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic strobe,
  input wire logic rc_timing_grounded,
  input wire logic sum_a_pos,
  input wire logic sum_b_pos,
  output logic supply_out,
  output logic supply_oe_n,
  output logic active,
  output scs_pkg::scs_result_s result
);

  localparam int WCW = $clog2(WIN_CYC);
  localparam int SETTLE_CYC = `SCS_SETTLE_CYC;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // a filtered bit moves only once the second and third stages agree
  function automatic logic [3:0] agree(input logic [3:0] s2, input logic [3:0] s3,
                                       input logic [3:0] cur);
    agree = (s2 & s3) | (cur & (s2 ^ s3));
  endfunction

  // next on_off level from the two results and the held level
  function automatic logic on_off_next(input logic a, input logic b, input logic held);
    on_off_next = a ? 1'b0 : (b ? 1'b1 : held);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 0 strobe, 1 rc_timing_grounded, 2 sum a sign, 3 sum b sign
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] filt_ff;
  logic strobe_prev_ff;

  // three stages; only the second stage reads the first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= `SCS_RST_SYNC;
      sync2_ff <= `SCS_RST_SYNC;
      sync3_ff <= `SCS_RST_SYNC;
    end else begin
      sync1_ff <= {sum_b_pos, sum_a_pos, rc_timing_grounded, strobe};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // agreement filter; a pulse near 50 ns may be too short to be seen at 25 mhz
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_ff <= `SCS_RST_SYNC;
      strobe_prev_ff <= 1'b0;
    end else begin
      filt_ff <= agree(sync2_ff, sync3_ff, filt_ff);
      strobe_prev_ff <= filt_ff[0];
    end
  end

  logic strobe_rise;
  logic osc_mode;
  logic osc_tick;

  assign strobe_rise = filt_ff[0] & ~strobe_prev_ff; // edge, not level
  assign osc_mode = ~filt_ff[1] & ~filt_ff[0]; // self-timed only while strobe low

  // ----------------------------------------------------------------
  // self-timed oscillator
  // ----------------------------------------------------------------
  scs_osc #(
    .PERIOD(OSC_PERIOD)
  ) u_osc (
    .clk(clk),
    .rstn(rstn),
    .run(osc_mode),
    .tick(osc_tick)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  scs_pkg::scs_state_e state_ff;
  scs_pkg::scs_state_e nxt_state;
  logic [WCW-1:0] win_cnt_ff;
  logic start;
  logic win_end;

  // a strobe edge in any mode starts a cycle; ticks only while self-timed
  assign start = strobe_rise | (osc_tick & osc_mode);
  assign win_end = (state_ff == scs_pkg::SCS_ACTIVE) && (win_cnt_ff == WCW'(WIN_CYC - 1));

  // next state; edges that arrive during a window are dropped, not queued
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      scs_pkg::SCS_IDLE: begin
        if (start) begin
          nxt_state = scs_pkg::SCS_ACTIVE;
        end
      end
      scs_pkg::SCS_ACTIVE: begin
        if (win_end) begin
          nxt_state = scs_pkg::SCS_IDLE;
        end
      end
      default: begin
        nxt_state = scs_pkg::SCS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= scs_pkg::SCS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // window timer, counts every cycle of the active window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt_ff <= '0;
    end else if (state_ff == scs_pkg::SCS_ACTIVE && !win_end) begin
      win_cnt_ff <= win_cnt_ff + WCW'(1);
    end else begin
      win_cnt_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // pulsed supply
  // ----------------------------------------------------------------
  logic supply_oe_n_ff;
  logic supply_out_ff;
  logic active_ff;

  // registered from the next state so the pin tracks the window exactly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      supply_oe_n_ff <= 1'b1;
      supply_out_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      supply_oe_n_ff <= (nxt_state != scs_pkg::SCS_ACTIVE);
      supply_out_ff <= (nxt_state == scs_pkg::SCS_ACTIVE);
      active_ff <= (nxt_state == scs_pkg::SCS_ACTIVE);
    end
  end

  // ----------------------------------------------------------------
  // output logic
  // ----------------------------------------------------------------
  scs_pkg::scs_result_s result_ff;
  scs_pkg::scs_result_s nxt_result;

  // the sign is taken in the last window cycle, long after settling
  always_comb begin
    nxt_result = result_ff;
    if (win_end) begin
      nxt_result.a = filt_ff[2];
      nxt_result.b = filt_ff[3];
      nxt_result.both_low = ~filt_ff[2] & ~filt_ff[3];
      nxt_result.on_off = on_off_next(filt_ff[2], filt_ff[3], result_ff.on_off);
    end
  end

  // results change only at a window end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_ff <= `SCS_RST_RESULT;
    end else begin
      result_ff <= nxt_result;
    end
  end

  assign supply_out = supply_out_ff;
  assign supply_oe_n = supply_oe_n_ff;
  assign active = active_ff;
  assign result = result_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_supply_drive: assert property (@(posedge clk) disable iff (!rstn)
    supply_oe_n_ff == (state_ff != scs_pkg::SCS_ACTIVE) && supply_out_ff == !supply_oe_n_ff)
    else $error("pulsed supply does not follow the active window");

  a_window_len: assert property (@(posedge clk) disable iff (!rstn)
    $fell(active_ff) |-> $past(win_cnt_ff) == WCW'(WIN_CYC - 1))
    else $error("active window ended at the wrong count");

  a_window_bound: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(active_ff) |-> win_cnt_ff == '0) and (active_ff || win_cnt_ff == '0) and (int'(win_cnt_ff) < WIN_CYC))
    else $error("window counter not restarted");

  a_settle_room: assert property (@(posedge clk) disable iff (!rstn)
    win_end |-> int'(win_cnt_ff) >= SETTLE_CYC)
    else $error("sign sampled before inputs could settle");

  a_both_low: assert property (@(posedge clk) disable iff (!rstn)
    result_ff.both_low == (!result_ff.a && !result_ff.b))
    else $error("both_low disagrees with results");

  a_result_sign: assert property (@(posedge clk) disable iff (!rstn)
    win_end |=> result_ff.a == $past(filt_ff[2]) && result_ff.b == $past(filt_ff[3]))
    else $error("result does not follow sum sign");

  a_onoff_level: assert property (@(posedge clk) disable iff (!rstn)
    (result_ff.a |-> !result_ff.on_off) and ((!result_ff.a && result_ff.b) |-> result_ff.on_off))
    else $error("on_off level wrong");

  a_onoff_hold: assert property (@(posedge clk) disable iff (!rstn)
    ($past(result_ff.both_low) && result_ff.both_low) |-> $stable(result_ff.on_off))
    else $error("on_off moved while both results low");

  a_strobe_start: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == scs_pkg::SCS_IDLE && strobe_rise) |=> active_ff ##1 supply_out_ff)
    else $error("strobe edge did not start a cycle");

  a_level_only: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == scs_pkg::SCS_IDLE && filt_ff[0] && strobe_prev_ff && !osc_tick) |=> !active_ff)
    else $error("held strobe level started a cycle");

  a_osc_start: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff == scs_pkg::SCS_IDLE && osc_tick && osc_mode) |=> active_ff)
    else $error("oscillator tick did not start a cycle");

  a_result_hold: assert property (@(posedge clk) disable iff (!rstn)
    !$stable(result_ff) |-> $past(win_end))
    else $error("results changed outside a window end");

  c_strobe_cycle: cover property (@(posedge clk) disable iff (!rstn)
    strobe_rise && state_ff == scs_pkg::SCS_IDLE ##1 active_ff);

  c_osc_cycle: cover property (@(posedge clk) disable iff (!rstn)
    osc_tick && osc_mode && state_ff == scs_pkg::SCS_IDLE);

  c_hold_on: cover property (@(posedge clk) disable iff (!rstn)
    result_ff.on_off && result_ff.both_low);

  c_edge_dropped: cover property (@(posedge clk) disable iff (!rstn)
    strobe_rise && state_ff == scs_pkg::SCS_ACTIVE);

endmodule

`default_nettype wire

/* sim/scs_sensor_model.sv */
/*
  behavioural model of the far side: a strobe source and the two sensor input networks.
  assumes the bench asks for cycles by raising fire, and that active marks the window.
*/
`timescale 1ns/1ps
`default_nettype none

module scs_sensor_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic want_a,
  input wire logic want_b,
  input wire logic active,
  output logic strobe,
  output logic sum_a_pos,
  output logic sum_b_pos
);
  // ----------------------------------------------------------------
  // power-up levels
  // ----------------------------------------------------------------
  initial begin
    strobe = 1'b0;
    sum_a_pos = 1'b0;
    sum_b_pos = 1'b0;
  end

  // ----------------------------------------------------------------
  // networks and strobe, moved off the sampling edge
  // ----------------------------------------------------------------
  // sums only move while no window runs and no strobe is up,
  // so they are settled long before the window ends, where the sign is taken, and stay put in it
  always @(negedge clk) begin
    if (!active && !strobe) begin
      sum_a_pos <= want_a;
      sum_b_pos <= want_b;
    end
  end

  // the pulse never falls inside a window, even if the bench lets go early
  always @(negedge clk) begin
    if (fire) begin
      strobe <= 1'b1;
    end else if (!active) begin
      strobe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/sampled_comparator_sequencer_bench.sv */
/*
  self-checking bench for scs_top: truth table rows, held strobe, self-timed mode, reset.
  assumes scs_top and the sensor model; window shortened to 120 cycles, oscillator to 300.
  the window must stay longer than the 4 us settle count, or the settle assertion fires.
*/
`timescale 1ns/1ps
`default_nettype none

module sampled_comparator_sequencer_bench;
  localparam int WIN = 120;
  localparam int OSC = 300;

  typedef struct packed {
    logic a;
    logic b;
    scs_pkg::scs_result_s r;
  } scs_row_s;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fire = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic rc_gnd = 1'b1;
  logic strobe;
  logic sum_a_pos;
  logic sum_b_pos;
  logic supply_out;
  logic supply_oe_n;
  logic active;
  scs_pkg::scs_result_s result;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  // on_off must hold across the two both-low rows
  scs_row_s rows [5] = '{'{1'b1, 1'b1, 4'hc}, '{1'b0, 1'b0, 4'h2}, '{1'b0, 1'b1, 4'h5},
                         '{1'b0, 1'b0, 4'h3}, '{1'b1, 1'b0, 4'h8}};

  always #20 clk = ~clk;

  scs_top #(.OSC_PERIOD(OSC), .WIN_CYC(WIN)) dut (.clk(clk), .rstn(rstn), .strobe(strobe),
    .rc_timing_grounded(rc_gnd), .sum_a_pos(sum_a_pos), .sum_b_pos(sum_b_pos),
    .supply_out(supply_out), .supply_oe_n(supply_oe_n), .active(active), .result(result));

  scs_sensor_model partner (.clk(clk), .fire(fire), .want_a(want_a), .want_b(want_b),
    .active(active), .strobe(strobe), .sum_a_pos(sum_a_pos), .sum_b_pos(sum_b_pos));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkr(input scs_pkg::scs_result_s got, input scs_pkg::scs_result_s exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t result=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch t=%0t count=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for active; running out of patience ends the run
  task automatic wait_for(input logic val, input int lim, output int cnt);
    cnt = 0;
    while (active !== val && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= lim) begin
      n_mismatch++;
      $display("mismatch t=%0t active=%h exp=%h", $time, active, val);
      test_done();
    end
  endtask

  // one whole window: supply during it, results held, then updated at its end
  task automatic run_window(input scs_pkg::scs_result_s exp, input int lim);
    int k;
    scs_pkg::scs_result_s prev;
    prev = result;
    wait_for(1'b1, lim, k);
    k = 0;
    while (active === 1'b1 && k < 2 * WIN) begin
      if (k == WIN / 2) begin
        chk1(supply_out, 1'b1);
        chk1(supply_oe_n, 1'b0);
        chkr(result, prev);
      end
      @(negedge clk);
      k++;
    end
    chkn(k, WIN);
    chk1(supply_out, 1'b0);
    chk1(supply_oe_n, 1'b1);
    chkr(result, exp);
  endtask

  task automatic chk_reset();
    chk1(active, 1'b0);
    chk1(supply_out, 1'b0);
    chk1(supply_oe_n, 1'b1);
    chkr(result, 4'h2);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    chk_reset();
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk_reset();
    $display("test reset done");
    // truth table rows, strobe held high well past each window
    for (int i = 0; i < 5; i++) begin
      want_a = rows[i].a;
      want_b = rows[i].b;
      fire = 1'b1;
      run_window(rows[i].r, 20);
      n = 0;
      repeat (WIN + 20) begin
        @(negedge clk);
        if (active !== 1'b0) n++;
      end
      chkn(n, 0);
      fire = 1'b0;
      repeat (8) @(negedge clk);
      $display("test row %0d done", i);
    end
    // self-timed: two windows one oscillator period apart
    want_a = 1'b0;
    want_b = 1'b1;
    rc_gnd = 1'b0;
    run_window(4'h5, OSC + 20);
    wait_for(1'b1, OSC + 20, n);
    chkn(WIN + n, OSC);
    run_window(4'h5, 20);
    rc_gnd = 1'b1;
    $display("test self-timed done");
    // reset in the middle of a window
    repeat (8) @(negedge clk);
    fire = 1'b1;
    wait_for(1'b1, 20, n);
    repeat (10) @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk_reset();
    fire = 1'b0;
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    // the strobe that was up across the reset must not start a window afterwards
    chk_reset();
    $display("test mid-window reset done");
    test_done();
  end
endmodule
`default_nettype wire
